// >>> src/kmc_debounce.sv
// per-key debouncer producing a stable level and a one-cycle press pulse
`default_nettype none
module kmc_debounce #(
   parameter int unsigned N = 8,
   parameter int unsigned CYC = 400000
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [N-1:0] raw,
   output logic [N-1:0] level,
   output logic [N-1:0] press
);
   localparam int unsigned CW = $clog2(CYC + 1);
   localparam logic [CW-1:0] LAST = CW'(CYC - 1);

   genvar g;
   generate
      for (g = 0; g < N; g++)
      begin : g_key
         logic [CW-1:0] cnt_r;
         logic stable_r;
         logic press_r;
         // a change must persist for the full window before it counts
         always_ff @(posedge clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               cnt_r <= '0;
               stable_r <= 1'b0;
               press_r <= 1'b0;
            end
            else
            begin
               press_r <= 1'b0;
               if (raw[g] == stable_r)
                  cnt_r <= '0;
               else if (cnt_r == LAST)
               begin
                  cnt_r <= '0;
                  stable_r <= raw[g];
                  press_r <= raw[g];
               end
               else
                  cnt_r <= cnt_r + 1'b1;
            end
         end
         assign level[g] = stable_r;
         assign press[g] = press_r;
      end
   endgenerate
endmodule
`default_nettype wire

// >>> src/kmc_defs.svh
// constants for the keypad menu controller: timing, key indices, offsets
`ifndef KMC_DEFS_SVH
`define KMC_DEFS_SVH

// --------------------------------------------------------------------
// timing
// --------------------------------------------------------------------
`define KMC_CLK_HZ 20000000
`define KMC_DEBOUNCE_US 20000
`define KMC_DEBOUNCE_CYC (`KMC_DEBOUNCE_US * (`KMC_CLK_HZ / 1000000))

// --------------------------------------------------------------------
// key positions in the raw key vector
// --------------------------------------------------------------------
`define KMC_KEY_PRG 0
`define KMC_KEY_DATA 1
`define KMC_KEY_REV 2
`define KMC_KEY_JOG 3
`define KMC_KEY_RUN 4
`define KMC_KEY_STOP 5
`define KMC_KEY_UP 6
`define KMC_KEY_DOWN 7
`define KMC_KEY_NUM 8

// --------------------------------------------------------------------
// register byte offsets (low eight address bits decoded)
// --------------------------------------------------------------------
`define KMC_A_CTRL 8'h00
`define KMC_A_STOP_SEL 8'h04
`define KMC_A_RUN_SEL_LO 8'h08
`define KMC_A_RUN_SEL_HI 8'h0C
`define KMC_A_PASSWORD 8'h10
`define KMC_A_DISP_ITEM 8'h14
`define KMC_A_STATUS 8'h18

// --------------------------------------------------------------------
// reset values and value limits
// --------------------------------------------------------------------
`define KMC_CTRL_RST 1'h0
`define KMC_STOP_SEL_RST 13'h0003
`define KMC_RUN_SEL_LO_RST 16'h001F
`define KMC_RUN_SEL_HI_RST 16'h0000
`define KMC_PASSWORD_RST 17'h00000
`define KMC_DISP_ITEM_RST 5'h00
`define KMC_STOP_ITEMS 13
`define KMC_VAL_MAX 17'h1869F
`define KMC_DIGIT_LAST 3'h4

`endif

// >>> src/kmc_pkg.sv
// types shared by the keypad menu controller
`default_nettype none
package kmc_pkg;

   typedef enum logic [4:0] {
      MS_STATUS = 5'b00001,
      MS_PASS = 5'b00010,
      MS_GROUP = 5'b00100,
      MS_CODE = 5'b01000,
      MS_VALUE = 5'b10000
   } kmc_menu_t;

   typedef enum logic [1:0] {
      RV_IDLE = 2'b01,
      RV_DECEL = 2'b10
   } kmc_rev_t;

   typedef struct packed {
      logic writable;
      logic stop_only;
   } kmc_attr_t;

   typedef struct packed {
      logic [3:0] group;
      logic [5:0] code;
   } kmc_paddr_t;

   typedef struct packed {
      kmc_menu_t mode;
      logic [4:0] item;
      logic [16:0] value;
      logic [2:0] digit;
      logic flash;
   } kmc_disp_t;

endpackage
`default_nettype wire

// >>> src/kmc_top.sv
// keypad menu controller: key decode, three-level menu, drive commands
//
// Contract
// - program key enters first menu level, or leaves an open group
// - data key in normal operation advances to the next status item
// - in programming, data shows value first, second press commits it
// - reversal key decelerates to zero, then runs the opposite direction
// - jog key issues jog outside editing, shifts edit digit left inside
// - run key starts drive, ignored when run source is terminals
// - stop key stops drive; after a fault it clears and resets
// - up/down step through items, or change the value being edited
// - menu levels: group, then code within group, then code value
// - data at value level saves, returns, selects next function code
// - program at value level returns without saving, same code
// - digit flashes only when editable; read-only items accept no edits
// - stop-only parameters reject edits while the drive runs
// - stopped state offers 13 items, each enabled by stopped select
// - running state offers 32 items, enabled by two running selects
// - each select bit enables one item; cycling skips disabled, wraps
// - selected status item survives power loss via software-held copy
// - nonzero password demands correct entry from zero before access
//
// Design decisions made here: the register addresses and the AHB-Lite slave port.
`include "kmc_defs.svh"
`default_nettype none
module kmc_top
   import kmc_pkg::*;
#(
   parameter int unsigned DEBOUNCE_CYC = `KMC_DEBOUNCE_CYC,
   parameter logic [3:0] GROUP_LAST = 4'hF,
   parameter logic [5:0] CODE_LAST = 6'h3F
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   input wire logic [`KMC_KEY_NUM-1:0] keys_raw,
   input wire logic [16:0] param_rd_data,
   input wire kmc_attr_t param_attr,
   input wire logic drive_running,
   input wire logic drive_fault,
   input wire logic motor_at_zero,
   output var kmc_paddr_t param_addr,
   output logic param_wr_en,
   output logic [16:0] param_wr_data,
   output logic run_cmd,
   output logic stop_cmd,
   output logic jog_cmd,
   output logic fault_reset,
   output logic decel_to_zero,
   output logic dir_reverse,
   output var kmc_disp_t display,
   output logic pass_prompt
);
   // ------------------------------------------------------------------
   // keys, state and editing arithmetic
   // ------------------------------------------------------------------
   // first enabled item after cur, wrapping; cur itself if none other
   function automatic logic [4:0] next_item(input logic [31:0] mask,
                                            input logic [4:0] cur);
      logic [4:0] res, idx;
      res = cur;
      for (int i = 32; i >= 1; i--)
      begin
         idx = cur + i[4:0];
         if (mask[idx])
            res = idx;
      end
      return res;
   endfunction
   // place weights 1, 10, 100, 1000, 10000 of the edited digit
   localparam logic [84:0] WEIGHTS = {17'h02710, 17'h003E8, 17'h00064,
                                      17'h0000A, 17'h00001};
   logic [`KMC_KEY_NUM-1:0] key_press, key_level;
   kmc_debounce #(.N(`KMC_KEY_NUM), .CYC(DEBOUNCE_CYC)) u_deb (
      .clk(hclk), .rst_n(hresetn), .raw(keys_raw),
      .level(key_level), .press(key_press));
   wire k_prg = key_press[`KMC_KEY_PRG], k_data = key_press[`KMC_KEY_DATA];
   wire k_rev = key_press[`KMC_KEY_REV], k_jog = key_press[`KMC_KEY_JOG];
   wire k_run = key_press[`KMC_KEY_RUN], k_stop = key_press[`KMC_KEY_STOP];
   wire k_up = key_press[`KMC_KEY_UP], k_down = key_press[`KMC_KEY_DOWN];
   logic run_src_term_r;
   logic [12:0] stop_sel_r;
   logic [15:0] run_sel_lo_r;
   logic [15:0] run_sel_hi_r;
   logic [16:0] password_r;
   logic [4:0] item_r, item_nxt;
   kmc_menu_t menu_r, menu_nxt;
   kmc_rev_t rev_r, rev_nxt;
   logic [3:0] group_r, group_nxt;
   logic [5:0] code_r, code_nxt;
   logic [16:0] val_r, val_nxt;
   logic [2:0] digit_r, digit_nxt;
   logic unlock_r, unlock_nxt;
   logic wr_r, wr_nxt, adv_r;
   logic dir_r, dir_nxt;
   wire [31:0] stop_mask = {{(32-`KMC_STOP_ITEMS){1'b0}},
                            stop_sel_r};
   wire [31:0] run_mask = {run_sel_hi_r, run_sel_lo_r};
   wire [31:0] cur_mask = drive_running ? run_mask : stop_mask;
   wire item_ev = (menu_r == MS_STATUS) && k_data;
   wire [16:0] weight = WEIGHTS[digit_r*17 +: 17];
   wire [17:0] val_sum = {1'b0, val_r} + {1'b0, weight};
   wire [16:0] val_inc = (val_sum > {1'b0, `KMC_VAL_MAX}) ? val_r
                                                          : val_sum[16:0];
   wire [16:0] val_dec = (val_r < weight) ? val_r : val_r - weight;
   wire [2:0] digit_left = (digit_r == `KMC_DIGIT_LAST) ? 3'h0
                                                        : digit_r + 3'h1;
   // stop-only items lock while running; read-only items always lock
   wire editable = param_attr.writable &&
                   !(param_attr.stop_only && drive_running);
   wire pw_set = (password_r != 17'h00000);
   wire can_edit = (menu_r == MS_PASS) ||
                   ((menu_r == MS_VALUE) && editable);
   wire [16:0] val_edit = !can_edit ? val_r : k_up ? val_inc :
                          k_down ? val_dec : val_r;
   wire [2:0] digit_edit = (can_edit && k_jog && !k_up && !k_down) ?
                           digit_left : digit_r;
   // ------------------------------------------------------------------
   // menu and reversal state machines
   // ------------------------------------------------------------------
   always_comb
   begin
      menu_nxt = menu_r;
      group_nxt = group_r;
      code_nxt = code_r;
      val_nxt = val_edit;
      digit_nxt = digit_edit;
      unlock_nxt = unlock_r;
      wr_nxt = 1'b0;
      item_nxt = item_r;
      case (menu_r)
         MS_STATUS:
         begin
            if (k_prg)
            begin
               // protection is back in force each time the menu is left
               menu_nxt = (pw_set && !unlock_r) ? MS_PASS : MS_GROUP;
               val_nxt = 17'h00000;
               digit_nxt = 3'h0;
            end
            else if (k_data)
               item_nxt = next_item(cur_mask, item_r);
         end
         MS_PASS:
         begin
            if (k_prg)
               menu_nxt = MS_STATUS;
            else if (k_data)
            begin
               unlock_nxt = (val_r == password_r);
               menu_nxt = unlock_nxt ? MS_GROUP : MS_PASS;
               val_nxt = 17'h00000;
               digit_nxt = 3'h0;
            end
         end
         MS_GROUP:
         begin
            if (k_prg)
               menu_nxt = MS_STATUS;
            else if (k_data)
            begin
               menu_nxt = MS_CODE;
               code_nxt = 6'h00;
            end
            else if (k_up)
               group_nxt = (group_r == GROUP_LAST) ? 4'h0 : group_r + 4'h1;
            else if (k_down)
               group_nxt = (group_r == 4'h0) ? GROUP_LAST : group_r - 4'h1;
         end
         MS_CODE:
         begin
            if (k_prg)
               menu_nxt = MS_GROUP;
            else if (k_data)
            begin
               menu_nxt = MS_VALUE;
               val_nxt = param_rd_data;
               digit_nxt = 3'h0;
            end
            else if (k_up)
               code_nxt = (code_r == CODE_LAST) ? 6'h00 : code_r + 6'h01;
            else if (k_down)
               code_nxt = (code_r == 6'h00) ? CODE_LAST : code_r - 6'h01;
         end
         MS_VALUE:
         begin
            if (k_prg)
               menu_nxt = MS_CODE;
            else if (k_data)
            begin
               menu_nxt = MS_CODE;
               wr_nxt = editable;
            end
         end
         default:
            menu_nxt = MS_STATUS;
      endcase
      // the write pulse must carry the saved code, so step one cycle later
      if (adv_r)
         code_nxt = (code_r == CODE_LAST) ? 6'h00 : code_r + 6'h01;
      if (menu_nxt == MS_STATUS)
         unlock_nxt = 1'b0;
   end
   always_comb
   begin
      rev_nxt = rev_r;
      dir_nxt = dir_r;
      case (rev_r)
         RV_IDLE:
            if (k_rev && drive_running)
               rev_nxt = RV_DECEL;
            else if (k_rev)
               dir_nxt = ~dir_r;
         RV_DECEL:
            if (motor_at_zero)
            begin
               // a running drive's direction flips only once the motor stands at zero
               rev_nxt = RV_IDLE;
               dir_nxt = ~dir_r;
            end
         default:
            rev_nxt = RV_IDLE;
      endcase
   end
   // ------------------------------------------------------------------
   // bus slave (zero wait, word only, always OKAY)
   // ------------------------------------------------------------------
   logic wph_r;
   logic [7:0] wadr_r;
   wire ahb_go = hsel && htrans[1] && hready;
   wire [7:0] radr = haddr[7:0];
   wire we_ctrl = wph_r && (wadr_r == `KMC_A_CTRL);
   wire we_stop = wph_r && (wadr_r == `KMC_A_STOP_SEL);
   wire we_rlo = wph_r && (wadr_r == `KMC_A_RUN_SEL_LO);
   wire we_rhi = wph_r && (wadr_r == `KMC_A_RUN_SEL_HI);
   wire we_pw = wph_r && (wadr_r == `KMC_A_PASSWORD);
   wire we_item = wph_r && (wadr_r == `KMC_A_DISP_ITEM);
   wire [31:0] status_word = {21'h000000, decel_to_zero, dir_r, unlock_r,
                              drive_running, menu_r, 2'h0};
   wire [31:0] rd_data =
      (radr == `KMC_A_CTRL) ? {31'h00000000, run_src_term_r} :
      (radr == `KMC_A_STOP_SEL) ? {19'h00000, stop_sel_r} :
      (radr == `KMC_A_RUN_SEL_LO) ? {16'h0000, run_sel_lo_r} :
      (radr == `KMC_A_RUN_SEL_HI) ? {16'h0000, run_sel_hi_r} :
      (radr == `KMC_A_PASSWORD) ? {15'h0000, password_r} :
      (radr == `KMC_A_DISP_ITEM) ? {27'h0000000, item_r} :
      (radr == `KMC_A_STATUS) ? status_word : 32'h00000000;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wph_r <= 1'b0;
         wadr_r <= 8'h00;
         hrdata <= 32'h00000000;
         run_src_term_r <= `KMC_CTRL_RST;
         stop_sel_r <= `KMC_STOP_SEL_RST;
         run_sel_lo_r <= `KMC_RUN_SEL_LO_RST;
         run_sel_hi_r <= `KMC_RUN_SEL_HI_RST;
         password_r <= `KMC_PASSWORD_RST;
      end
      else
      begin
         wph_r <= ahb_go && hwrite;
         wadr_r <= radr;
         hrdata <= (ahb_go && !hwrite) ? rd_data : 32'h00000000;
         if (we_ctrl)
            run_src_term_r <= hwdata[0];
         if (we_stop)
            stop_sel_r <= hwdata[12:0];
         if (we_rlo)
            run_sel_lo_r <= hwdata[15:0];
         if (we_rhi)
            run_sel_hi_r <= hwdata[15:0];
         if (we_pw)
            password_r <= hwdata[16:0];
      end
   end
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         menu_r <= MS_STATUS;
         rev_r <= RV_IDLE;
         group_r <= 4'h0;
         code_r <= 6'h00;
         val_r <= 17'h00000;
         digit_r <= 3'h0;
         unlock_r <= 1'b0;
         wr_r <= 1'b0;
         adv_r <= 1'b0;
         dir_r <= 1'b0;
         item_r <= `KMC_DISP_ITEM_RST;
         run_cmd <= 1'b0;
         stop_cmd <= 1'b0;
         fault_reset <= 1'b0;
         jog_cmd <= 1'b0;
      end
      else
      begin
         menu_r <= menu_nxt;
         rev_r <= rev_nxt;
         group_r <= group_nxt;
         code_r <= code_nxt;
         val_r <= val_nxt;
         digit_r <= digit_nxt;
         unlock_r <= unlock_nxt;
         wr_r <= wr_nxt;
         adv_r <= (menu_r == MS_VALUE) && k_data && !k_prg;
         dir_r <= dir_nxt;
         // a key step beats a software restore in the same cycle
         item_r <= item_ev ? item_nxt :
                   we_item ? hwdata[4:0] : item_r;
         run_cmd <= k_run && !run_src_term_r;
         stop_cmd <= k_stop && !drive_fault;
         fault_reset <= k_stop && drive_fault;
         jog_cmd <= key_level[`KMC_KEY_JOG] &&
                    (menu_r != MS_VALUE) && (menu_r != MS_PASS);
      end
   end
   assign param_addr = '{group: group_r, code: code_r};
   assign param_wr_en = wr_r;
   assign param_wr_data = val_r;
   assign decel_to_zero = (rev_r == RV_DECEL);
   assign dir_reverse = dir_r;
   assign pass_prompt = (menu_r == MS_PASS);
   assign display = '{mode: menu_r, item: item_r, value: val_r,
                      digit: digit_r, flash: can_edit};
endmodule
`default_nettype wire

// >>> testbench/kmc_checker.sv
// assertion checker on the keypad menu controller ports
`default_nettype none
module kmc_checker
   import kmc_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire kmc_attr_t param_attr,
   input wire logic drive_running,
   input wire logic drive_fault,
   input wire logic motor_at_zero,
   input wire logic param_wr_en,
   input wire logic run_cmd,
   input wire logic stop_cmd,
   input wire logic jog_cmd,
   input wire logic fault_reset,
   input wire logic decel_to_zero,
   input wire logic dir_reverse,
   input wire kmc_disp_t display,
   input wire logic pass_prompt
);
   timeunit 1ns;
   timeprecision 1ns;
   // ------
   // helpers
   // ------
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   wire logic rd_req = hsel & htrans[1] & ~hwrite & hready;
   wire logic edit_ok = param_attr.writable &
      ~(param_attr.stop_only & drive_running);
   wire logic cmd_any = run_cmd | stop_cmd | fault_reset | param_wr_en;
   sequence s_wait_zero;
      decel_to_zero && !motor_at_zero;
   endsequence
   sequence s_at_zero;
      decel_to_zero && motor_at_zero;
   endsequence
   // ------
   // properties
   // ------
   a_decel_holds: assert property (
      s_wait_zero |=> decel_to_zero && $stable(dir_reverse))
      else $error("decel left early");
   a_decel_ends: assert property (
      s_at_zero |=> !decel_to_zero && dir_reverse != $past(dir_reverse))
      else $error("no flip at zero");
   a_save_return: assert property (
      param_wr_en |-> display.mode == MS_CODE &&
      $past(display.mode) == MS_VALUE)
      else $error("save did not return to code level");
   a_write_gated: assert property (
      param_wr_en |-> $past(edit_ok))
      else $error("write on a locked value");
   a_no_flash: assert property (
      display.mode == MS_VALUE && !edit_ok |-> !display.flash)
      else $error("flash shown on a locked value");
   a_pulse_single: assert property (
      cmd_any |=> !cmd_any)
      else $error("long pulse");
   a_stop_plain: assert property (
      stop_cmd |-> !$past(drive_fault))
      else $error("stop issued while faulted");
   a_fault_clear: assert property (
      fault_reset |-> $past(drive_fault))
      else $error("fault reset without fault");
   a_jog_outside: assert property (
      jog_cmd |-> display.mode inside {MS_STATUS, MS_GROUP, MS_CODE})
      else $error("jog issued while editing");
   a_prompt_mode: assert property (
      pass_prompt == (display.mode == MS_PASS))
      else $error("prompt mismatch");
   a_menu_onehot: assert property (
      $onehot(display.mode))
      else $error("menu state not one-hot");
   a_rdata_phase: assert property (
      hrdata != 32'h0 |-> $past(rd_req))
      else $error("read data outside a data phase");
endmodule
`default_nettype wire

// >>> testbench/kmc_operator.sv
// operator model: presses one key, holds it, then releases it
`default_nettype none
module kmc_operator (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic go,
   input wire logic [2:0] key,
   input wire logic [7:0] len,
   output logic [7:0] keys_raw,
   output logic busy
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [8:0] cnt_r;
   assign busy = (cnt_r != 9'h000);
   // release lasts as long as the hold so the debouncer sees it
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         cnt_r <= 9'h000;
         keys_raw <= 8'h00;
      end
      else if (go)
      begin
         cnt_r <= {len, 1'b0};
         keys_raw <= 8'h01 << key;
      end
      else if (busy)
      begin
         cnt_r <= cnt_r - 9'h001;
         if (cnt_r == {1'b0, len})
            keys_raw <= 8'h00;
      end
   end
endmodule
`default_nettype wire

// >>> testbench/tb_top.sv
// self-checking bench for the keypad menu controller
`include "kmc_defs.svh"
`default_nettype none
`define CHK(g, e) \
   begin \
      n_tests++; \
      if ((g) !== (e)) \
      begin \
         mismatches++; \
         $display("ERROR %0t got %h exp %h", $time, (g), (e)); \
      end \
   end
module tb_top
   import kmc_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ns;
   logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hready;
   logic [31:0] haddr = '0, hwdata = '0, hrdata, rd, msk;
   logic [1:0] htrans = '0;
   logic [2:0] hsize = 3'h2, key = '0;
   logic [7:0] keys_raw, len = '0;
   logic [16:0] param_rd_data = '0, param_wr_data, v;
   kmc_attr_t param_attr = '0;
   kmc_paddr_t param_addr;
   kmc_disp_t display;
   logic drive_running = 0, drive_fault = 0, motor_at_zero = 0;
   logic hreadyout, hresp, param_wr_en, run_cmd, stop_cmd, jog_cmd;
   logic fault_reset, decel_to_zero, dir_reverse, pass_prompt;
   logic go = 0, busy;
   int mismatches = 0, n_tests = 0;
   logic [31:0] exp_q[$];
   assign hready = hreadyout;
   always #25 hclk = ~hclk;
   kmc_top #(.DEBOUNCE_CYC(4)) kmc_top_inst (.hclk(hclk),
      .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
      .keys_raw(keys_raw), .param_rd_data(param_rd_data),
      .param_attr(param_attr), .drive_running(drive_running),
      .drive_fault(drive_fault), .motor_at_zero(motor_at_zero),
      .param_addr(param_addr), .param_wr_en(param_wr_en),
      .param_wr_data(param_wr_data), .run_cmd(run_cmd),
      .stop_cmd(stop_cmd), .jog_cmd(jog_cmd), .fault_reset(fault_reset),
      .decel_to_zero(decel_to_zero), .dir_reverse(dir_reverse),
      .display(display), .pass_prompt(pass_prompt));
   kmc_operator kmc_operator_inst (.hclk(hclk), .hresetn(hresetn),
      .go(go), .key(key), .len(len), .keys_raw(keys_raw), .busy(busy));
   // ------
   // tasks
   // ------
   task automatic print_verdict();
      $display("compares %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic wait_on(input bit want_busy);
      for (int i = 0; i < 100; i++)
      begin
         @(posedge hclk);
         if ((want_busy ? hready : !busy) === 1'b1)
            return;
      end
      mismatches++;
      print_verdict();
   endtask
   task automatic bus(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1;
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'b10;
      wait_on(1);
      hsel <= 0;
      htrans <= 2'b00;
      hwdata <= d;
      wait_on(1);
      rd = hrdata;
   endtask
   task automatic start(input int k, input int l);
      @(posedge hclk);
      go <= 1;
      key <= 3'(k);
      len <= 8'(l);
      @(posedge hclk);
      go <= 0;
   endtask
   // idle gap lets every response settle before it is checked
   task automatic press(input int k, input int l = 8);
      start(k, l);
      wait_on(0);
      repeat (2) @(posedge hclk);
   endtask
   function automatic logic [4:0] nxt(logic [31:0] m, logic [4:0] c,
      int n);
      int j;
      for (int i = 1; i <= n; i++)
      begin
         j = (c + i) % n;
         if (m[j])
            return 5'(j);
      end
      return c;
   endfunction
   always @(posedge hclk)
   begin : monitor
      logic [31:0] r, e;
      if (hresetn && (param_wr_en | run_cmd | stop_cmd | fault_reset))
      begin
         r = {1'b0, run_cmd, stop_cmd, fault_reset, param_wr_en,
            param_wr_en ? {param_addr, param_wr_data} : 27'h0};
         e = exp_q.size() > 0 ? exp_q.pop_front() : ~r;
         `CHK(r, e)
      end
   end
   // ------
   // scenarios
   // ------
   initial
   begin
      logic [7:0] ra[7];
      logic [31:0] rv[7];
      logic [4:0] it;
      ra = '{`KMC_A_CTRL, `KMC_A_STOP_SEL, `KMC_A_RUN_SEL_LO,
         `KMC_A_RUN_SEL_HI, `KMC_A_PASSWORD, `KMC_A_DISP_ITEM, 8'h1C};
      rv = '{32'h0, 32'h3, 32'h1F, 32'h0, 32'h0, 32'h0, 32'h0};
      void'($urandom(56811));
      repeat (5) @(posedge hclk);
      hresetn <= 1;
      for (int i = 0; i < 7; i++)
      begin
         bus(0, ra[i], 32'h0);
         `CHK(rd, rv[i])
      end
      $display("test registers done");
      msk = $urandom & 32'h1FFF;
      bus(1, `KMC_A_STOP_SEL, msk);
      it = 5'h00;
      for (int i = 0; i < 4; i++)
      begin
         it = nxt(msk, it, 13);
         press(`KMC_KEY_DATA);
         `CHK(display.item, it)
      end
      drive_running <= 1;
      msk = $urandom;
      bus(1, `KMC_A_RUN_SEL_LO, {16'h0, msk[15:0]});
      bus(1, `KMC_A_RUN_SEL_HI, {16'h0, msk[31:16]});
      for (int i = 0; i < 4; i++)
      begin
         it = nxt(msk, it, 32);
         press(`KMC_KEY_DATA);
         `CHK(display.item, it)
      end
      drive_running <= 0;
      bus(1, `KMC_A_DISP_ITEM, 32'h5);
      bus(0, `KMC_A_DISP_ITEM, 32'h0);
      `CHK(rd, 32'h5)
      `CHK(display.item, 5'h05)
      $display("test status items done");
      v = 17'($urandom_range(99000));
      param_rd_data <= v;
      param_attr <= 2'b10;
      press(`KMC_KEY_PRG);
      `CHK(display.mode, MS_GROUP)
      press(`KMC_KEY_DATA);
      `CHK(display.mode, MS_CODE)
      press(`KMC_KEY_UP);
      `CHK(param_addr.code, 6'h01)
      press(`KMC_KEY_DATA);
      `CHK(display.value, v)
      `CHK(display.flash, 1'b1)
      press(`KMC_KEY_UP);
      press(`KMC_KEY_JOG);
      `CHK(display.digit, 3'h1)
      press(`KMC_KEY_UP);
      `CHK(display.value, v + 17'd11)
      exp_q.push_back({5'b00001, 4'h0, 6'h01, v + 17'd11});
      press(`KMC_KEY_DATA);
      `CHK(param_addr.code, 6'h02)
      press(`KMC_KEY_DATA);
      press(`KMC_KEY_UP);
      press(`KMC_KEY_PRG);
      `CHK(display.mode, MS_CODE)
      `CHK(param_addr.code, 6'h02)
      param_attr <= 2'b11;
      drive_running <= 1;
      press(`KMC_KEY_DATA);
      `CHK(display.flash, 1'b0)
      press(`KMC_KEY_UP);
      `CHK(display.value, v)
      press(`KMC_KEY_DATA);
      drive_running <= 0;
      param_attr <= 2'b10;
      press(`KMC_KEY_PRG);
      `CHK(display.mode, MS_GROUP)
      press(`KMC_KEY_PRG);
      `CHK(display.mode, MS_STATUS)
      start(`KMC_KEY_JOG, 20);
      repeat (12) @(posedge hclk);
      `CHK(jog_cmd, 1'b1)
      wait_on(0);
      $display("test menu done");
      bus(1, `KMC_A_PASSWORD, 32'h3);
      press(`KMC_KEY_PRG);
      `CHK(pass_prompt, 1'b1)
      `CHK(display.value, 17'h0)
      press(`KMC_KEY_UP);
      press(`KMC_KEY_DATA);
      `CHK(display.value, 17'h0)
      repeat (4) press(`KMC_KEY_UP);
      press(`KMC_KEY_DOWN);
      press(`KMC_KEY_DATA);
      `CHK(display.mode, MS_GROUP)
      press(`KMC_KEY_PRG);
      bus(1, `KMC_A_PASSWORD, 32'h0);
      $display("test password done");
      bus(1, `KMC_A_CTRL, 32'h1);
      press(`KMC_KEY_RUN);
      bus(1, `KMC_A_CTRL, 32'h0);
      exp_q.push_back({5'b01000, 27'h0});
      press(`KMC_KEY_RUN);
      exp_q.push_back({5'b00100, 27'h0});
      press(`KMC_KEY_STOP);
      drive_fault <= 1;
      exp_q.push_back({5'b00010, 27'h0});
      press(`KMC_KEY_STOP);
      drive_fault <= 0;
      press(`KMC_KEY_RUN, 2);
      drive_running <= 1;
      press(`KMC_KEY_REV);
      `CHK(decel_to_zero, 1'b1)
      `CHK(dir_reverse, 1'b0)
      motor_at_zero <= 1;
      repeat (3) @(posedge hclk);
      `CHK(decel_to_zero, 1'b0)
      `CHK(dir_reverse, 1'b1)
      `CHK(exp_q.size(), 0)
      $display("test commands done");
      print_verdict();
   end
endmodule
bind kmc_top kmc_checker kmc_checker_inst (.hclk(hclk),
   .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
   .hready(hready), .hrdata(hrdata), .param_attr(param_attr),
   .drive_running(drive_running), .drive_fault(drive_fault),
   .motor_at_zero(motor_at_zero), .param_wr_en(param_wr_en),
   .run_cmd(run_cmd), .stop_cmd(stop_cmd), .jog_cmd(jog_cmd),
   .fault_reset(fault_reset), .decel_to_zero(decel_to_zero),
   .dir_reverse(dir_reverse), .display(display),
   .pass_prompt(pass_prompt));
`default_nettype wire
